//--- hw/ssc_sleep_ctrl.sv
`timescale 1ns/1ns
module ssc_sleep_ctrl (
	input wire logic clk_sys, // system clock, 25 MHz
	input wire logic rst, // synchronous reset, high
	input wire logic supplyOk, // supply at turn-on level and in range
	input wire logic [1:0] enStrapCode, // enable strap level code
	input wire logic [1:0] wakeThresholdStrap, // program strap level code
	input wire logic enAboveOn, // enable pin above its on threshold
	input wire logic enBelowOff, // enable pin below its off threshold
	input wire logic [1:0] drainSenseInputs, // each drain above arming level
	input wire logic cycleTick, // one pulse per switching clock cycle
	input wire logic [6:0] dutyPct, // measured conduction duty, percent
	output logic gateAllow, // rectifier gate drive permitted
	output logic lowPower, // low-consumption state
	input wire logic hsel, // ahb slave select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size, word only
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic [31:0] hrdata, // ahb read data
	output logic hreadyout, // ahb slave ready
	output logic hresp // ahb response
);
	import ssc_pkg::*;

	localparam int STOP_W = $clog2(STOP_CYCLES + 1);
	localparam logic [STOP_W-1:0] STOP_LAST = STOP_W'(STOP_CYCLES);
	localparam logic [8:0] LOW_LAST = 9'(LOW_DUTY_TICKS - 1);
	localparam logic [4:0] WAKE_LAST = 5'(WAKE_DELAY_TICKS - 1);
	localparam logic [4:0] SETTLE_LAST = 5'(STRAP_SETTLE_CYCLES - 1);

	ssc_cfg_if cfg ();

	ssc_state_t state;
	ssc_state_t next_state;
	logic [STOP_W-1:0] stopCnt;
	logic [8:0] lowCnt;
	logic [4:0] wakeCnt;
	logic [4:0] settleCnt;
	logic forceOff;
	logic busWrite;
	logic [7:0] busAddr;

	wire logic stopped;
	wire logic remoteOff;
	wire logic remoteOn;
	wire logic lowDuty;
	wire logic enterSleep;
	wire logic wakeSeen;
	wire logic wakeDone;
	wire logic settleDone;
	wire logic addrPhase;
	wire logic [31:0] readMux;
	wire logic [31:0] statusWord;
	wire logic [31:0] configWord;

	ssc_strap_loader u_loader (
		.clk_sys(clk_sys),
		.rst(rst),
		.cfg(cfg.loader)
	);

	// sample at end of start-up settle
	assign settleDone = (state == ST_START) && (settleCnt == SETTLE_LAST);
	assign cfg.sample = settleDone;
	assign cfg.enCode = enStrapCode;
	assign cfg.progCode = wakeThresholdStrap;
	assign cfg.clear = ~supplyOk;

	assign stopped = (stopCnt == STOP_LAST);
	// software off acts like the pin
	assign remoteOff = enBelowOff | forceOff;
	assign remoteOn = enAboveOn & ~forceOff;
	// low duty counts only with sleep on
	assign lowDuty = cfg.sleepOn && (dutyPct < cfg.offDuty);
	assign enterSleep = (state == ST_RUN) && cycleTick && lowDuty
		&& (lowCnt == LOW_LAST);
	assign wakeSeen = (state == ST_LOW) && remoteOn && !stopped && cycleTick
		&& (dutyPct > cfg.onDuty);
	assign wakeDone = (state == ST_WAKE) && cycleTick && (wakeCnt == WAKE_LAST);

	// remote off and stopped switching win over everything in operation except supply loss
	always_comb begin
		next_state = state;
		unique case (state)
			ST_DOWN: begin
				next_state = ST_START;
			end
			ST_START: begin
				if (settleDone) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (remoteOff || stopped || enterSleep) begin
					next_state = ST_LOW;
				end
			end
			ST_LOW: begin
				if (wakeSeen) begin
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (remoteOff || stopped) begin
					next_state = ST_LOW;
				end else if (wakeDone) begin
					next_state = ST_RUN;
				end
			end
		endcase
		if (!supplyOk) begin
			next_state = ST_DOWN;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_DOWN;
			gateAllow <= 1'b0;
			lowPower <= 1'b0;
		end else begin
			state <= next_state;
			gateAllow <= (next_state == ST_RUN);
			lowPower <= (next_state == ST_LOW) || (next_state == ST_WAKE);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || state != ST_START) begin
			settleCnt <= 5'h00;
		end else if (!settleDone) begin
			settleCnt <= settleCnt + 5'h01;
		end
	end

	// idle timer saturates at the limit
	always_ff @(posedge clk_sys) begin
		if (rst || !(&drainSenseInputs)) begin
			stopCnt <= '0;
		end else if (!stopped) begin
			stopCnt <= stopCnt + STOP_W'(1);
		end
	end

	// any good-duty cycle restarts the count
	always_ff @(posedge clk_sys) begin
		if (rst || state != ST_RUN) begin
			lowCnt <= 9'h000;
		end else if (cycleTick) begin
			lowCnt <= lowDuty ? lowCnt + 9'h001 : 9'h000;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || state != ST_WAKE) begin
			wakeCnt <= 5'h00;
		end else if (cycleTick && !wakeDone) begin
			wakeCnt <= wakeCnt + 5'h01;
		end
	end

	// ahb-lite slave, zero wait states, always okay
	assign addrPhase = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign statusWord = {24'h000000, gateAllow, lowPower, cfg.valid,
		cfg.sleepOn, 1'b0, state};
	assign configWord = {17'h00000, cfg.onDuty, 1'b0, cfg.offDuty};
	// unmapped and sub-word addresses read as zero
	assign readMux = (haddr[7:0] == CTRL_OFFSET) ? {31'h0, forceOff} :
		(haddr[7:0] == STATUS_OFFSET) ? statusWord :
		(haddr[7:0] == CONFIG_OFFSET) ? configWord : 32'h00000000;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busWrite <= 1'b0;
			busAddr <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			busWrite <= addrPhase & hwrite;
			busAddr <= haddr[7:0];
			// read data sampled at the address phase, so a read right
			// after a write to ctrl still shows the old value
			if (addrPhase && !hwrite) begin
				hrdata <= (haddr[31:8] == 24'h000000) ? readMux : 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			forceOff <= CTRL_FORCE_OFF_RESET;
		end else if (busWrite && busAddr == CTRL_OFFSET) begin
			forceOff <= hwdata[CTRL_FORCE_OFF_BIT];
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_startup_sample: assert property (
		$rose(cfg.valid) |-> $past(state) == ST_START && state == ST_RUN)
		else $error("config latched outside start-up");
	a_config_hold: assert property (
		cfg.valid && supplyOk |=> cfg.valid && $stable(cfg.onDuty)
		&& $stable(cfg.offDuty) && $stable(cfg.sleepOn))
		else $error("latched config changed while supply ok");
	a_remote_off: assert property (
		supplyOk && state == ST_RUN && enBelowOff |=> state == ST_LOW && lowPower)
		else $error("remote off did not enter low power");
	a_resume_cause: assert property (
		state == ST_LOW ##1 state == ST_WAKE |-> $past(enAboveOn)
		&& $past(dutyPct) > cfg.onDuty)
		else $error("resumed without enable high and duty above exit");
	a_no_duty_sleep: assert property (
		supplyOk && state == ST_RUN && !cfg.sleepOn && !remoteOff && !stopped
		|=> state == ST_RUN)
		else $error("left operation on duty with sleep disabled");
	a_no_gate_low: assert property (
		state == ST_LOW || state == ST_WAKE |-> !gateAllow)
		else $error("gate allowed in low power");
	a_stop_time: assert property (
		stopped |-> $past(&drainSenseInputs) && stopCnt == 9'd500)
		else $error("stop detected at wrong time");
	a_wake_delay: assert property (
		$past(state) == ST_WAKE && state == ST_RUN |-> $past(wakeCnt) == 5'd23
		&& $past(cycleTick))
		else $error("wake delay not 24 cycles");
	a_sleep_count: assert property (
		enterSleep |-> lowCnt == 9'd511 && dutyPct < cfg.offDuty)
		else $error("sleep entered before 512 low cycles");
	a_supply_clear: assert property (
		!supplyOk |=> !cfg.valid && state == ST_DOWN)
		else $error("supply loss did not clear config");
	a_down_restart: assert property (
		state == ST_DOWN && supplyOk |=> state == ST_START)
		else $error("no new start-up after supply returned");
	a_start_no_gate: assert property (
		state == ST_START |-> !gateAllow && !lowPower)
		else $error("outputs active during start-up");
	a_settle_time: assert property (
		$past(state) == ST_START && state == ST_RUN
		|-> $past(settleCnt) == SETTLE_LAST)
		else $error("straps sampled before settle time");

	// operation and low power
	a_gate_only_run: assert property (
		gateAllow |-> state == ST_RUN)
		else $error("gate allowed outside operation");
	a_low_power_out: assert property (
		lowPower |-> state == ST_LOW || state == ST_WAKE)
		else $error("low power flag outside low power states");
	a_stop_low: assert property (
		supplyOk && state == ST_RUN && stopped
		|=> state == ST_LOW && lowPower)
		else $error("stopped switching did not force low power");
	a_low_hold: assert property (
		supplyOk && state == ST_LOW && !remoteOn |=> state == ST_LOW)
		else $error("left low power while remote off held");
	a_exit_strict: assert property (
		supplyOk && state == ST_LOW && dutyPct <= cfg.onDuty
		|=> state == ST_LOW)
		else $error("woke with duty not above exit level");
	a_tick_gated: assert property (
		supplyOk && state == ST_RUN && !cycleTick && !remoteOff
		&& !stopped |=> state == ST_RUN)
		else $error("sleep entered between switching cycles");

	// register bus
	a_ctrl_write: assert property (
		busWrite && busAddr == CTRL_OFFSET
		&& hwdata[CTRL_FORCE_OFF_BIT] |=> forceOff)
		else $error("software remote off not taken");
	a_status_read: assert property (
		addrPhase && !hwrite && haddr == {24'h000000, STATUS_OFFSET}
		|=> hrdata[2:0] == $past(state))
		else $error("status read shows wrong state");
	a_unmapped_zero: assert property (
		addrPhase && !hwrite && haddr > {24'h000000, CONFIG_OFFSET}
		|=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule : ssc_sleep_ctrl

//--- pkg/ssc_pkg.sv
package ssc_pkg;
	// timing
	localparam int CLK_MHZ = 25;
	localparam int STOP_TIME_NS = 20000;
	localparam int STOP_CYCLES = (STOP_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int LOW_DUTY_TICKS = 512;
	localparam int WAKE_DELAY_TICKS = 24;
	localparam int STRAP_SETTLE_CYCLES = 16;

	// register map, byte addresses
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] CONFIG_OFFSET = 8'h08;
	localparam int CTRL_FORCE_OFF_BIT = 0;
	localparam logic CTRL_FORCE_OFF_RESET = 1'b0;
	localparam int STATUS_STATE_LSB = 0;
	localparam int STATUS_SLEEP_BIT = 4;
	localparam int STATUS_VALID_BIT = 5;
	localparam int STATUS_LOW_BIT = 6;
	localparam int STATUS_GATE_BIT = 7;
	localparam int CONFIG_OFF_LSB = 0;
	localparam int CONFIG_ON_LSB = 8;

	// enable strap codes
	localparam logic [1:0] EN_R100K = 2'h0;
	localparam logic [1:0] EN_R180K = 2'h1;
	localparam logic [1:0] EN_OPEN = 2'h2;
	// program strap codes: short, 100k, 180k, open
	localparam logic [1:0] PG_SHORT = 2'h0;
	localparam logic [1:0] PG_R100K = 2'h1;
	localparam logic [1:0] PG_R180K = 2'h2;
	localparam logic [1:0] PG_OPEN = 2'h3;

	// duty thresholds in percent; sleep levels by enable strap, wake tables indexed by program strap code
	localparam logic [6:0] SLEEP_DUTY_R100K = 7'h28;
	localparam logic [6:0] SLEEP_DUTY_R180K = 7'h19;
	localparam logic [6:0] SLEEP_DUTY_OPEN = 7'h00;
	localparam logic [6:0] WAKE_TAB_R100K [4] = '{7'h50, 7'h4b, 7'h41, 7'h3c};
	localparam logic [6:0] WAKE_TAB_R180K [4] = '{7'h4b, 7'h46, 7'h3c, 7'h37};
	localparam logic [6:0] WAKE_TAB_OPEN [4] = '{7'h50, 7'h4b, 7'h41, 7'h00};

	typedef enum logic [2:0] {
		ST_DOWN, ST_START, ST_RUN, ST_LOW, ST_WAKE
	} ssc_state_t;
endpackage : ssc_pkg

//--- pkg/ssc_cfg_if.sv
`timescale 1ns/1ns
interface ssc_cfg_if;
	logic sample;
	logic clear;
	logic [1:0] enCode;
	logic [1:0] progCode;
	logic valid;
	logic sleepOn;
	logic [6:0] offDuty;
	logic [6:0] onDuty;

	modport loader (
		input sample, clear, enCode, progCode,
		output valid, sleepOn, offDuty, onDuty
	);
	modport user (
		output sample, clear, enCode, progCode,
		input valid, sleepOn, offDuty, onDuty
	);
endinterface : ssc_cfg_if

//--- hw/ssc_strap_loader.sv
`timescale 1ns/1ns
module ssc_strap_loader (
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, high
	ssc_cfg_if.loader cfg // strap codes in, latched config out
);
	import ssc_pkg::*;

	wire logic takeNow;
	wire logic next_sleepOn;
	wire logic [6:0] next_offDuty;
	wire logic [6:0] next_onDuty;

	assign takeNow = cfg.sample & ~cfg.valid;
	// only a 100k or 180k strap enables sleep
	assign next_sleepOn = (cfg.enCode == EN_R100K) | (cfg.enCode == EN_R180K);
	assign next_offDuty = (cfg.enCode == EN_R100K) ? SLEEP_DUTY_R100K :
		(cfg.enCode == EN_R180K) ? SLEEP_DUTY_R180K : SLEEP_DUTY_OPEN;
	assign next_onDuty = (cfg.enCode == EN_R100K) ? WAKE_TAB_R100K[cfg.progCode] :
		(cfg.enCode == EN_R180K) ? WAKE_TAB_R180K[cfg.progCode] :
		WAKE_TAB_OPEN[cfg.progCode];

	always_ff @(posedge clk_sys) begin
		if (rst || cfg.clear) begin
			cfg.valid <= 1'b0;
			cfg.sleepOn <= 1'b0;
			cfg.offDuty <= 7'h00;
			cfg.onDuty <= 7'h00;
		end else if (takeNow) begin
			cfg.valid <= 1'b1;
			cfg.sleepOn <= next_sleepOn;
			cfg.offDuty <= next_offDuty;
			cfg.onDuty <= next_onDuty;
		end
	end

	a_open_no_sleep: assert property (@(posedge clk_sys) disable iff (rst)
		takeNow && !cfg.clear && cfg.enCode[1] |=> !cfg.sleepOn && cfg.valid)
		else $error("open enable strap left sleep enabled");
	a_r100k_table: assert property (@(posedge clk_sys) disable iff (rst)
		takeNow && !cfg.clear && cfg.enCode == EN_R100K && cfg.progCode == PG_OPEN
		|=> cfg.offDuty == 7'h28 && cfg.onDuty == 7'h3c && cfg.sleepOn)
		else $error("100k strap thresholds wrong");
	a_r180k_table: assert property (@(posedge clk_sys) disable iff (rst)
		takeNow && !cfg.clear && cfg.enCode == EN_R180K && cfg.progCode == PG_SHORT
		|=> cfg.offDuty == 7'h19 && cfg.onDuty == 7'h4b)
		else $error("180k strap thresholds wrong");
	a_open_exit: assert property (@(posedge clk_sys) disable iff (rst)
		takeNow && !cfg.clear && cfg.enCode == EN_OPEN && cfg.progCode == PG_R180K
		|=> cfg.onDuty == 7'h41)
		else $error("open strap exit duty wrong");
endmodule : ssc_strap_loader

//--- verification/ssc_strap_net.sv
`timescale 1ns/1ns
module ssc_strap_net (
	input wire logic [1:0] enRes, // 0 100k, 1 180k, 2 or 3 open
	input wire logic [1:0] pgRes, // 0 short, 1 100k, 2 180k, 3 open
	input wire logic switchOn, // remote off transistor closed
	output logic [1:0] enStrapCode, // sensed enable strap level
	output logic [1:0] wakeThresholdStrap, // sensed program strap level
	output logic enAboveOn, // pin above on level
	output logic enBelowOff // pin below off level
);
	// resistor or pull-up sets level
	// a closed switch grounds the pin, so it reads as the lowest strap
	assign enStrapCode = switchOn ? 2'h0 : enRes;
	assign wakeThresholdStrap = pgRes;
	assign enAboveOn = !switchOn;
	assign enBelowOff = switchOn;
endmodule : ssc_strap_net

//--- verification/sleep_mode_strap_config_tb_top.sv
`timescale 1ns/1ns
module sleep_mode_strap_config_tb_top;
	logic clk_sys = 1'b0;
	logic rst, supplyOk, switchOn, cycleTick, hsel, hwrite;
	logic [1:0] enRes, pgRes, enStrapCode, wakeThresholdStrap;
	logic enAboveOn, enBelowOff, gateAllow, lowPower, hreadyout, hresp;
	logic [1:0] drainSenseInputs, htrans;
	logic [6:0] dutyPct;
	logic [31:0] haddr, hwdata, hrdata, d;
	int errCount = 0;
	int samplesChecked = 0;
	logic [6:0] wakeExp [3][4] = '{'{7'h50, 7'h4b, 7'h41, 7'h3c},
		'{7'h4b, 7'h46, 7'h3c, 7'h37}, '{7'h50, 7'h4b, 7'h41, 7'h00}};
	logic [6:0] sleepExp [3] = '{7'h28, 7'h19, 7'h00};

	always #20 clk_sys = ~clk_sys;

	ssc_strap_net u_ssc_strap_net (.enRes(enRes), .pgRes(pgRes),
		.switchOn(switchOn), .enStrapCode(enStrapCode),
		.wakeThresholdStrap(wakeThresholdStrap), .enAboveOn(enAboveOn),
		.enBelowOff(enBelowOff));

	ssc_sleep_ctrl u_ssc_sleep_ctrl (.clk_sys(clk_sys), .rst(rst),
		.supplyOk(supplyOk), .enStrapCode(enStrapCode),
		.wakeThresholdStrap(wakeThresholdStrap), .enAboveOn(enAboveOn),
		.enBelowOff(enBelowOff), .drainSenseInputs(drainSenseInputs),
		.cycleTick(cycleTick), .dutyPct(dutyPct), .gateAllow(gateAllow),
		.lowPower(lowPower), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

	task automatic summarize;
		if (errCount == 0 && samplesChecked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// outputs are looked at mid-cycle, away from the edge's updates
	task automatic look(input logic g, input logic l);
		@(negedge clk_sys);
		chk({30'h0, gateAllow, lowPower}, {30'h0, g, l});
		@(posedge clk_sys);
	endtask : look

	task automatic waitRdy;
		int n;
		n = 0;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				errCount++;
				$display("[FAIL] %0t bus ready timeout", $time);
				summarize;
			end
			@(posedge clk_sys);
		end
	endtask : waitRdy

	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		waitRdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitRdy;
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic tick(input int n, input logic [6:0] dv);
		repeat (n) begin
			dutyPct <= dv;
			cycleTick <= 1'b1;
			@(posedge clk_sys);
			cycleTick <= 1'b0;
			@(posedge clk_sys);
		end
	endtask : tick

	task automatic startUp(input logic [1:0] e, input logic [1:0] p);
		int n;
		supplyOk <= 1'b0;
		switchOn <= 1'b0;
		enRes <= e;
		pgRes <= p;
		repeat (3) @(posedge clk_sys);
		supplyOk <= 1'b1;
		for (n = 0; n < 100 && gateAllow !== 1'b1; n++) @(negedge clk_sys);
		if (gateAllow !== 1'b1) begin
			errCount++;
			$display("[FAIL] %0t start-up timeout", $time);
			summarize;
		end
		@(posedge clk_sys);
	endtask : startUp

	initial begin
		rst = 1'b1;
		supplyOk = 1'b0;
		switchOn = 1'b0;
		enRes = 2'h2;
		pgRes = 2'h3;
		drainSenseInputs = 2'h0;
		cycleTick = 1'b0;
		dutyPct = 7'h00;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		bus(8'h00, 1'b0, 32'h0, d);
		chk(d, 32'h0);
		for (int e = 0; e < 3; e++) begin
			for (int p = 0; p < 4; p++) begin
				startUp(e[1:0], p[1:0]);
				bus(8'h08, 1'b0, 32'h0, d);
				chk(d, {17'h0, wakeExp[e][p], 1'b0,
					sleepExp[e]});
				bus(8'h04, 1'b0, 32'h0, d);
				chk(d, {24'h0, 3'b101, e != 2, 4'h2});
			end
		end
		// the fourth enable code also counts as an open strap
		startUp(2'h3, 2'h3);
		bus(8'h04, 1'b0, 32'h0, d);
		chk(d, 32'h000000a2);
		enRes <= 2'h0;
		pgRes <= 2'h0;
		repeat (4) @(posedge clk_sys);
		bus(8'h08, 1'b0, 32'h0, d);
		chk(d, 32'h0);
		tick(600, 7'h01);
		look(1'b1, 1'b0);
		drainSenseInputs <= 2'h3;
		repeat (478) @(posedge clk_sys);
		look(1'b1, 1'b0);
		repeat (40) @(posedge clk_sys);
		look(1'b0, 1'b1);
		drainSenseInputs <= 2'h0;
		tick(30, 7'h00);
		look(1'b0, 1'b1);
		tick(24, 7'h01);
		look(1'b0, 1'b1);
		tick(1, 7'h01);
		repeat (2) @(posedge clk_sys);
		look(1'b1, 1'b0);
		startUp(2'h0, 2'h1);
		switchOn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		look(1'b0, 1'b1);
		switchOn <= 1'b0;
		tick(30, 7'h4b);
		look(1'b0, 1'b1);
		tick(25, 7'h4c);
		repeat (2) @(posedge clk_sys);
		look(1'b1, 1'b0);
		tick(511, 7'h27);
		look(1'b1, 1'b0);
		tick(1, 7'h27);
		repeat (2) @(posedge clk_sys);
		look(1'b0, 1'b1);
		startUp(2'h1, 2'h0);
		bus(8'h00, 1'b1, 32'h1, d);
		repeat (3) @(posedge clk_sys);
		look(1'b0, 1'b1);
		bus(8'h00, 1'b0, 32'h0, d);
		chk(d, 32'h1);
		bus(8'h0c, 1'b1, 32'hffffffff, d);
		bus(8'h0c, 1'b0, 32'h0, d);
		chk(d, 32'h0);
		supplyOk <= 1'b0;
		repeat (3) @(posedge clk_sys);
		bus(8'h04, 1'b0, 32'h0, d);
		chk({28'h0, d[5], d[2:0]}, 32'h0);
		summarize;
	end
endmodule : sleep_mode_strap_config_tb_top
